// >>> hdl/mscsr_counter.sv
`timescale 1ns/1ns
module mscsr_counter
    import mscsr_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             masterClockOutOne,
    input  wire logic             masterClockOutTwo,
    input  wire logic             clkSelTwo,
    output logic [CNT_W-1:0]      count
);

    logic [1:0]       pinMeta_ff;
    logic [1:0]       pinSync_ff;
    logic             selPrev_ff;
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic             selLevel;
    logic             selRise;

    // Two stages per pin; stage one feeds only stage two
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pinMeta_ff[gi] <= 1'b0;
                    pinSync_ff[gi] <= 1'b0;
                end else begin
                    pinMeta_ff[gi] <= (gi == 0) ? masterClockOutOne : masterClockOutTwo;
                    pinSync_ff[gi] <= pinMeta_ff[gi];
                end
            end
        end
    endgenerate

    // source select
    // Changing select may add one spurious count
    assign selLevel  = clkSelTwo ? pinSync_ff[1] : pinSync_ff[0];
    assign selRise   = selLevel & ~selPrev_ff;
    // wrapping increment
    // Source must stay below half of mclk
    assign nxt_count = selRise ? count_ff + CNT_STEP : count_ff;
    assign count     = count_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            selPrev_ff <= 1'b0;
            count_ff   <= CNT_RESET;
        end else begin
            selPrev_ff <= selLevel;
            count_ff   <= nxt_count;
        end
    end

    property p_count_on_edge;
        @(posedge mclk) disable iff (!nrst)
        selRise |=> count_ff == $past(count_ff) + CNT_STEP;
    endproperty
    a_count_on_edge: assert property (p_count_on_edge)
        else $error("count did not step on source edge");

    property p_count_idle;
        @(posedge mclk) disable iff (!nrst)
        !selRise |=> $stable(count_ff);
    endproperty
    a_count_idle: assert property (p_count_idle)
        else $error("count moved without source edge");

endmodule : mscsr_counter

// >>> hdl/mscsr_pkg.sv
// Summary of operation
// - A 16-bit counter advances once per cycle of the selected codec master clock and software can never stop or load it.
// - Every start-of-frame event copies the current counter value into the capture byte pair.
// - The counter is clocked by either the first or the second master clock output, as chosen by a select input.
// - Reading the low capture byte at ffe4 returns bits 7:0 of the captured count.
// - Reading the high capture byte at ffe3 returns bits 15:8 of the captured count.
// - Both capture bytes are read-only, change only at a start of frame and reset to zero.
// - The second synthesizer frequency word is 24 bits made of three byte-wide read/write registers.
// - Byte 0 of the frequency word, bits 7:0, is written and read back at fff9 and resets to zero.
// - Byte 1 of the frequency word, bits 15:8, is written and read back at fff8 and resets to zero.
// - Byte 2 of the frequency word, bits 23:16, is written and read back at fff7 and resets to zero.
package mscsr_pkg;

    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam int          CNT_W           = 16;
    localparam int          FREQ_W          = 24;
    localparam int          SYNC_STAGES     = 2;

    localparam logic [15:0] ADDR_CAP_HIGH   = 16'hffe3;
    localparam logic [15:0] ADDR_CAP_LOW    = 16'hffe4;
    localparam logic [15:0] ADDR_FREQ_B2    = 16'hfff7;
    localparam logic [15:0] ADDR_FREQ_B1    = 16'hfff8;
    localparam logic [15:0] ADDR_FREQ_B0    = 16'hfff9;

    localparam int          CAP_LOW_LSB     = 0;
    localparam int          CAP_HIGH_LSB    = 8;
    localparam int          FREQ_B0_LSB     = 0;
    localparam int          FREQ_B1_LSB     = 8;
    localparam int          FREQ_B2_LSB     = 16;

    localparam logic [15:0] CAP_RESET       = 16'h0000;
    localparam logic [7:0]  FREQ_BYTE_RESET = 8'h00;
    localparam logic [7:0]  RD_UNMAPPED     = 8'h00;
    localparam logic [7:0]  RD_RESET        = 8'h00;
    localparam logic [15:0] CNT_RESET       = 16'h0000;
    localparam logic [15:0] CNT_STEP        = 16'h0001;

endpackage : mscsr_pkg

// >>> hdl/mscsr_top.sv
`timescale 1ns/1ns
module mscsr_top
    import mscsr_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic              masterClockOutOne,
    input  wire logic              masterClockOutTwo,
    input  wire logic              clkSelTwo,
    input  wire logic              sofPulse,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic              wrEn,
    input  wire logic              rdEn,
    output logic      [DATA_W-1:0] rdData,
    output logic      [FREQ_W-1:0] synthFrequencyWord
);

    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  capturedCount_ff;
    logic [CNT_W-1:0]  nxt_capturedCount;
    logic [DATA_W-1:0] freqByte0_ff;
    logic [DATA_W-1:0] freqByte1_ff;
    logic [DATA_W-1:0] freqByte2_ff;
    logic [DATA_W-1:0] nxt_freqByte0;
    logic [DATA_W-1:0] nxt_freqByte1;
    logic [DATA_W-1:0] nxt_freqByte2;
    logic [DATA_W-1:0] rdData_ff;
    logic [DATA_W-1:0] nxt_rdData;
    logic [DATA_W-1:0] rdMux;
    logic              hitCapHigh;
    logic              hitCapLow;
    logic              hitFreqB0;
    logic              hitFreqB1;
    logic              hitFreqB2;

    mscsr_counter u_counter (
        .mclk              (mclk),
        .nrst              (nrst),
        .masterClockOutOne (masterClockOutOne),
        .masterClockOutTwo (masterClockOutTwo),
        .clkSelTwo         (clkSelTwo),
        .count             (count)
    );

    assign hitCapHigh = (addr == ADDR_CAP_HIGH);
    assign hitCapLow  = (addr == ADDR_CAP_LOW);
    assign hitFreqB0  = (addr == ADDR_FREQ_B0);
    assign hitFreqB1  = (addr == ADDR_FREQ_B1);
    assign hitFreqB2  = (addr == ADDR_FREQ_B2);

    // no bus write path to capture
    assign nxt_capturedCount = sofPulse ? count : capturedCount_ff;

    assign nxt_freqByte0 = (wrEn && hitFreqB0) ? wrData : freqByte0_ff;
    assign nxt_freqByte1 = (wrEn && hitFreqB1) ? wrData : freqByte1_ff;
    assign nxt_freqByte2 = (wrEn && hitFreqB2) ? wrData : freqByte2_ff;

    assign synthFrequencyWord = {freqByte2_ff, freqByte1_ff, freqByte0_ff};

    // read decode
    // Unmapped addresses read as zero
    assign rdMux = hitCapLow  ? capturedCount_ff[CAP_LOW_LSB +: DATA_W]  :
                   hitCapHigh ? capturedCount_ff[CAP_HIGH_LSB +: DATA_W] :
                   hitFreqB0  ? freqByte0_ff :
                   hitFreqB1  ? freqByte1_ff :
                   hitFreqB2  ? freqByte2_ff : RD_UNMAPPED;
    assign nxt_rdData = rdEn ? rdMux : rdData_ff;
    assign rdData     = rdData_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            capturedCount_ff <= CAP_RESET;
        end else begin
            capturedCount_ff <= nxt_capturedCount;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            freqByte0_ff <= FREQ_BYTE_RESET;
            freqByte1_ff <= FREQ_BYTE_RESET;
            freqByte2_ff <= FREQ_BYTE_RESET;
        end else begin
            freqByte0_ff <= nxt_freqByte0;
            freqByte1_ff <= nxt_freqByte1;
            freqByte2_ff <= nxt_freqByte2;
        end
    end

    // Read data holds until the next read
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdData_ff <= RD_RESET;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    property p_count_step;
        (count != $past(count)) |-> (count == $past(count) + CNT_STEP);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("count did not step by one modulo 2^16");

    property p_capture_on_sof;
        sofPulse |=> capturedCount_ff == $past(count);
    endproperty
    a_capture_on_sof: assert property (p_capture_on_sof)
        else $error("capture missed start of frame");

    property p_capture_hold;
        !sofPulse |=> $stable(capturedCount_ff);
    endproperty
    a_capture_hold: assert property (p_capture_hold)
        else $error("capture changed without start of frame");

    property p_read_cap_low;
        rdEn && hitCapLow |=> rdData == $past(capturedCount_ff[7:0]);
    endproperty
    a_read_cap_low: assert property (p_read_cap_low)
        else $error("low capture read wrong");

    property p_read_cap_high;
        rdEn && hitCapHigh |=> rdData == $past(capturedCount_ff[15:8]);
    endproperty
    a_read_cap_high: assert property (p_read_cap_high)
        else $error("high capture read wrong");

    property p_write_b0;
        wrEn && hitFreqB0 ##1 !wrEn ##1 rdEn && hitFreqB0 && !wrEn
            |=> rdData == $past(wrData, 3);
    endproperty
    a_write_b0: assert property (p_write_b0)
        else $error("byte 0 read back wrong");

    property p_write_b1;
        wrEn && hitFreqB1 |=> synthFrequencyWord[15:8] == $past(wrData);
    endproperty
    a_write_b1: assert property (p_write_b1)
        else $error("byte 1 not stored");

    property p_write_b2;
        wrEn && hitFreqB2 |=> synthFrequencyWord[23:16] == $past(wrData);
    endproperty
    a_write_b2: assert property (p_write_b2)
        else $error("byte 2 not stored");

    property p_word_hold;
        !(wrEn && (hitFreqB0 || hitFreqB1 || hitFreqB2)) |=> $stable(synthFrequencyWord);
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("frequency word changed without write");

    property p_ro_write;
        wrEn && (hitCapLow || hitCapHigh) && !sofPulse |=> $stable(capturedCount_ff);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("capture byte took a bus write");

    property p_unmapped_zero;
        rdEn && !(hitCapLow || hitCapHigh || hitFreqB0 || hitFreqB1 || hitFreqB2)
            |=> rdData == RD_UNMAPPED;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");

    c_sof_capture: cover property (sofPulse ##1 capturedCount_ff != CAP_RESET);
    c_wrap: cover property (count == 16'hffff ##[1:1000] count == 16'h0000);
    c_read_low: cover property (rdEn && hitCapLow);
    c_write_b2: cover property (wrEn && hitFreqB2 && wrData != FREQ_BYTE_RESET);

endmodule : mscsr_top

// >>> sim/mscsr_mclk_src.sv
`timescale 1ns/1ns
module mscsr_mclk_src #(
    parameter int HALF_ONE = 200,
    parameter int HALF_TWO = 300
) (
    output logic masterClockOutOne,
    output logic masterClockOutTwo
);
    // two selectable sources
    // Offset keeps edges clear of mclk edges, so counts are exact
    initial begin
        masterClockOutOne = 1'b0;
        #30;
        forever #HALF_ONE masterClockOutOne = ~masterClockOutOne;
    end

    initial begin
        masterClockOutTwo = 1'b0;
        #30;
        forever #HALF_TWO masterClockOutTwo = ~masterClockOutTwo;
    end
endmodule : mscsr_mclk_src

// >>> sim/mscsr_top_tb.sv
`timescale 1ns/1ns
module mscsr_top_tb;
    import mscsr_pkg::*;
    logic              mclk;
    logic              nrst;
    logic              clkSelTwo;
    logic              sofPulse;
    logic              wrEn;
    logic              rdEn;
    logic              one;
    logic              two;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    logic [FREQ_W-1:0] synthFrequencyWord;
    int                badCount;
    int                nChecks;

    mscsr_mclk_src src_u (.masterClockOutOne(one), .masterClockOutTwo(two));

    mscsr_top dut_u (.mclk(mclk), .nrst(nrst), .masterClockOutOne(one),
        .masterClockOutTwo(two), .clkSelTwo(clkSelTwo), .sofPulse(sofPulse),
        .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
        .synthFrequencyWord(synthFrequencyWord));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        nChecks++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge mclk);
        wrEn <= 1'b0;
    endtask : wr

    // Read data is sampled mid-cycle, after the registered update
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge mclk);
        rdEn <= 1'b0;
        @(negedge mclk);
        d = rdData;
    endtask : rd

    task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("read %h", a), {16'h0000, exp}, {16'h0000, d});
    endtask : rdChk

    task automatic sof();
        @(posedge mclk);
        sofPulse <= 1'b1;
        @(posedge mclk);
        sofPulse <= 1'b0;
    endtask : sof

    task automatic capRead(output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(ADDR_CAP_LOW, lo);
        rd(ADDR_CAP_HIGH, hi);
        v = {hi, lo};
    endtask : capRead

    task automatic t_reset();
        rdChk(ADDR_CAP_HIGH, 8'h00);
        rdChk(ADDR_CAP_LOW, 8'h00);
        rdChk(ADDR_FREQ_B0, 8'h00);
        rdChk(ADDR_FREQ_B1, 8'h00);
        rdChk(ADDR_FREQ_B2, 8'h00);
        chk("freq word", 24'h000000, synthFrequencyWord);
        // Capture bytes must ignore software writes
        wr(ADDR_CAP_HIGH, 8'hff);
        wr(ADDR_CAP_LOW, 8'hff);
        rdChk(ADDR_CAP_HIGH, 8'h00);
        rdChk(ADDR_CAP_LOW, 8'h00);
        rdChk(16'hfffa, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_freq();
        wr(ADDR_FREQ_B0, 8'h5a);
        wr(ADDR_FREQ_B1, 8'hc3);
        wr(ADDR_FREQ_B2, 8'h81);
        @(negedge mclk);
        chk("freq word", 24'h81c35a, synthFrequencyWord);
        rdChk(ADDR_FREQ_B0, 8'h5a);
        rdChk(ADDR_FREQ_B1, 8'hc3);
        rdChk(ADDR_FREQ_B2, 8'h81);
        wr(ADDR_FREQ_B1, 8'h3c);
        wr(16'hfffa, 8'hff);
        @(negedge mclk);
        chk("freq word", 24'h813c5a, synthFrequencyWord);
        $display("test freq done");
    endtask : t_freq

    // SOF samples are 240 mclk cycles apart: 6 task edges plus 234
    task automatic t_cap(input logic sel, input int per);
        logic [15:0] v1;
        logic [15:0] v2;
        logic [15:0] v3;
        @(posedge mclk);
        clkSelTwo <= sel;
        repeat (20) @(posedge mclk);
        sof();
        capRead(v1);
        repeat (234) @(posedge mclk);
        sof();
        capRead(v2);
        chk("capture delta", 24'(240 / per), {8'h00, 16'(v2 - v1)});
        repeat (50) @(posedge mclk);
        capRead(v3);
        chk("capture held", {8'h00, v2}, {8'h00, v3});
        $display("test capture sel %0d done", sel);
    endtask : t_cap

    task automatic conclude();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge mclk);
        badCount++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        nrst = 1'b0;
        clkSelTwo = 1'b0;
        sofPulse = 1'b0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        addr = 16'h0000;
        wrData = 8'h00;
        badCount = 0;
        nChecks = 0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_freq();
        t_cap(1'b0, 4);
        t_cap(1'b1, 6);
        conclude();
    end
endmodule : mscsr_top_tb
